// file: logic/check_if.sv
`timescale 1ns/1ps
`default_nettype none
interface check_if;
    import fifo_check_pkg::*;
    logic checkOn;
    logic byteStb;
    logic [7:0] byteData;
    logic align;
    key_set_type key;
    logic resWrite;
    logic almClear;
    logic [7:0] wData;
    logic [7:0] resultBits;
    logic checkAlarm;
    modport source (output checkOn, byteStb, byteData, align, key, resWrite, almClear, wData,
        input resultBits, checkAlarm);
    modport sink (input checkOn, byteStb, byteData, align, key, resWrite, almClear, wData,
        output resultBits, checkAlarm);
endinterface : check_if
`default_nettype wire

// file: logic/fifo_check_pkg.sv
// Contract
// - Mode bits select dual or single sync.
// - Path select low bypasses the FIFO.
// - Pointers never touch bypass data path.
// - Dual mode: frame resets write, strobe read.
// - Output strobe sampled on conversion clock.
// - Single mode: read reset resampled from write.
// - Single mode devices may differ two cycles.
// - Both channels of one device share phase.
// - Check mode deactivates outputs despite transmit allow.
// - Eight key registers; word zero resets 0x7A.
// - Frame edge aligns key zero, words follow.
// - Tracking continues without further frame edges.
// - Mismatching lanes set their result bits.
// - Mismatch sets alarm bit 3; others invalid.
// - Writing zeros clears unless errors persist.
// - Pointer reset: write 0, read to offset.
// - Frame latched on rising edges resets pointers.
// - Alarms for pointers two, one, zero apart.
package fifo_check_pkg;
    localparam int ADDR_W = 5;
    localparam int KEY_WORDS = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    // Register offsets
    localparam logic [ADDR_W-1:0] CORE_CTRL_ADDR = 5'h00;
    localparam logic [ADDR_W-1:0] TEST_CTRL_ADDR = 5'h01;
    localparam logic [ADDR_W-1:0] RD_OFFSET_ADDR = 5'h03;
    localparam logic [ADDR_W-1:0] ALARM_STATUS_ADDR = 5'h07;
    localparam logic [ADDR_W-1:0] CHECK_RESULT_ADDR = 5'h08;
    localparam logic [ADDR_W-1:0] KEY_BASE_ADDR = 5'h09;
    localparam logic [ADDR_W-1:0] KEY_LAST_ADDR = 5'h10;
    localparam logic [ADDR_W-1:0] SYNC_SEL_ADDR = 5'h13;
    // Field positions
    localparam int FIFO_ENA_BIT = 0;
    localparam int RESET_ALLOW_BIT = 1;
    localparam int RDSYNC_ALLOW_BIT = 2;
    localparam int CHECK_ON_BIT = 0;
    localparam int SYNC_SRC_BIT = 0;
    localparam int ALARM_2AWAY_BIT = 0;
    localparam int ALARM_1AWAY_BIT = 1;
    localparam int ALARM_COLLIDE_BIT = 2;
    localparam int CHECK_ALARM_BIT = 3;
    // Values after reset
    localparam logic [2:0] CORE_CTRL_RST = 3'h7;
    localparam logic TEST_CTRL_RST = 1'b0;
    localparam logic SYNC_SEL_RST = 1'b0;
    localparam logic [PTR_W-1:0] RD_OFFSET_RST = 3'h4;
    localparam logic [PTR_W-1:0] WR_PTR_RST = 3'h0;
    typedef logic [KEY_WORDS-1:0][7:0] key_set_type;
    localparam key_set_type KEY_RST = {8'hc6, 8'haa, 8'h16, 8'h1a, 8'h45, 8'hea, 8'hb6, 8'h7a};
    typedef enum logic [3:0] {
        MODE_BYPASS = 4'b0001,
        MODE_DUAL = 4'b0010,
        MODE_SINGLE = 4'b0100,
        MODE_FREE = 4'b1000
    } fifo_mode_type;
endpackage : fifo_check_pkg

// file: logic/input_fifo_check.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module input_fifo_check
    import fifo_check_pkg::*;
#(
    parameter int INTERP = 2
) (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRData,
    // Data link pins
    input wire logic inputDataClock,
    input wire logic [7:0] dataByte,
    input wire logic frameMarker,
    // Clock distributor pins
    input wire logic conversionClock,
    input wire logic outputStrobe,
    input wire logic transmitAllow,
    // Converter side
    output logic [15:0] chanI,
    output logic [15:0] chanQ,
    output logic sampleValid,
    output logic outputsActive,
    output logic alarmOutPin
);
    localparam int PIN_W = 13;
    localparam int DCLK_BIT = 12;
    localparam int CONV_BIT = 11;
    localparam int OUTPUT_STROBE_BIT = 10;
    localparam int FRAME_BIT = 9;
    localparam int TXA_BIT = 8;
    localparam logic [2:0] DIV_LAST = 3'(INTERP - 1);

    // Pin synchronisers
    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] pinS1_r;
    logic [PIN_W-1:0] pinS2_r;
    logic [PIN_W-1:0] pinS3_r;
    logic [PIN_W-1:0] pinLvl_r;
    // Control registers
    logic [2:0] coreCtrl_r;
    logic checkOn_r;
    logic syncSel_r;
    logic [PTR_W-1:0] rdOffset_r;
    key_set_type key_r;
    logic [7:0] regRData_r;
    // Write side
    logic dclkPrev_r;
    logic frameLast_r;
    logic [1:0] byteIdx_r;
    logic [23:0] asm_r;
    logic [31:0] latest_r;
    logic [31:0] fifoMem_r [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    // Read side
    logic convPrev_r;
    logic ostrAtConv_r;
    logic [2:0] divCnt_r;
    logic wrRstSeen_r;
    logic rdRst1_r;
    logic rdRst2_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [31:0] outWord_r;
    logic sampleValid_r;
    logic outputsActive_r;
    // Combinational
    fifo_mode_type mode;
    logic dclkRise;
    logic dclkEdge;
    logic frameRise;
    logic resetAllowed;
    logic convRise;
    logic ostrRise;
    logic readTick;
    logic [7:0] linkByte;
    logic [PTR_W-1:0] ptrDist;
    logic [3:0] alarmBits;
    logic keyHit;
    logic [PTR_W-1:0] keySel;

    check_if chk ();

    // Three-stage capture of every foreign input
    assign pinRaw = {inputDataClock, conversionClock, outputStrobe, frameMarker, transmitAllow, dataByte};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_r <= '0;
            pinS2_r <= '0;
            pinS3_r <= '0;
        end else begin
            pinS1_r <= pinRaw;
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
        end
    end

    // A change counts once stages two and three agree
    for (genvar g = 0; g < PIN_W; g++) begin : gen_pinLevel
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pinLvl_r[g] <= 1'b0;
            end else if (pinS2_r[g] == pinS3_r[g]) begin
                pinLvl_r[g] <= pinS3_r[g];
            end
        end
    end

    // FIFO operating mode
    always_comb begin
        if (!coreCtrl_r[FIFO_ENA_BIT]) begin
            mode = MODE_BYPASS;
        end else if (coreCtrl_r[RESET_ALLOW_BIT] && coreCtrl_r[RDSYNC_ALLOW_BIT]) begin
            mode = syncSel_r ? MODE_SINGLE : MODE_DUAL;
        end else begin
            mode = MODE_FREE;
        end
    end

    // Edge finding on the link and conversion clocks
    assign linkByte = pinLvl_r[7:0];
    assign dclkRise = pinLvl_r[DCLK_BIT] && !dclkPrev_r;
    assign dclkEdge = pinLvl_r[DCLK_BIT] != dclkPrev_r;
    assign frameRise = dclkRise && pinLvl_r[FRAME_BIT] && !frameLast_r;
    assign resetAllowed = (mode == MODE_DUAL) || (mode == MODE_SINGLE);
    assign convRise = pinLvl_r[CONV_BIT] && !convPrev_r;
    assign ostrRise = convRise && pinLvl_r[OUTPUT_STROBE_BIT] && !ostrAtConv_r;
    assign readTick = convRise && (divCnt_r == DIV_LAST);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dclkPrev_r <= 1'b0;
            convPrev_r <= 1'b0;
        end else begin
            dclkPrev_r <= pinLvl_r[DCLK_BIT];
            convPrev_r <= pinLvl_r[CONV_BIT];
        end
    end

    // Frame marker latched on rising data clock edges only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frameLast_r <= 1'b0;
        end else if (dclkRise) begin
            frameLast_r <= pinLvl_r[FRAME_BIT];
        end
    end

    // Byte assembly, four DDR bytes to one I/Q sample
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byteIdx_r <= 2'h0;
            asm_r <= 24'h000000;
            latest_r <= 32'h00000000;
        end else if (frameRise) begin
            byteIdx_r <= 2'h1;
            asm_r[23:16] <= linkByte;
        end else if (dclkEdge) begin
            byteIdx_r <= byteIdx_r + 2'h1;
            unique case (byteIdx_r)
                2'h0: asm_r[23:16] <= linkByte;
                2'h1: asm_r[15:8] <= linkByte;
                2'h2: asm_r[7:0] <= linkByte;
                2'h3: latest_r <= {asm_r, linkByte};
            endcase
        end
    end

    // FIFO write and write pointer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= WR_PTR_RST;
        end else if (frameRise && resetAllowed) begin
            wrPtr_r <= WR_PTR_RST;
        end else if (dclkEdge && byteIdx_r == 2'h3) begin
            wrPtr_r <= wrPtr_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dclkEdge && !frameRise && byteIdx_r == 2'h3) begin
            fifoMem_r[wrPtr_r] <= {asm_r, linkByte};
        end
    end

    // Output strobe sampled on conversion clock; FIFO read clock divider
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ostrAtConv_r <= 1'b0;
            divCnt_r <= 3'h0;
        end else if (convRise) begin
            ostrAtConv_r <= pinLvl_r[OUTPUT_STROBE_BIT];
            if (mode == MODE_DUAL && ostrRise) begin
                divCnt_r <= 3'h0;
            end else if (divCnt_r == DIV_LAST) begin
                divCnt_r <= 3'h0;
            end else begin
                divCnt_r <= divCnt_r + 3'h1;
            end
        end
    end

    // Write-side reset resampled by the read clock; may slip two cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wrRstSeen_r <= 1'b0;
            rdRst1_r <= 1'b0;
            rdRst2_r <= 1'b0;
        end else begin
            if (frameRise && mode == MODE_SINGLE) begin
                wrRstSeen_r <= 1'b1;
            end else if (readTick) begin
                wrRstSeen_r <= 1'b0;
            end
            if (readTick) begin
                rdRst1_r <= wrRstSeen_r;
                rdRst2_r <= rdRst1_r;
            end
        end
    end

    // Read pointer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdPtr_r <= RD_OFFSET_RST;
        end else if (mode == MODE_DUAL && ostrRise) begin
            rdPtr_r <= rdOffset_r;
        end else if (readTick && mode == MODE_SINGLE && rdRst2_r) begin
            rdPtr_r <= rdOffset_r;
        end else if (readTick && mode != MODE_BYPASS) begin
            rdPtr_r <= rdPtr_r + 3'h1;
        end
    end

    // Output word; both channels leave together from one entry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outWord_r <= 32'h00000000;
            sampleValid_r <= 1'b0;
        end else begin
            sampleValid_r <= readTick;
            if (readTick && mode == MODE_BYPASS) begin
                outWord_r <= latest_r;
            end else if (readTick) begin
                outWord_r <= fifoMem_r[rdPtr_r];
            end
        end
    end

    // Analog outputs off while checking
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outputsActive_r <= 1'b0;
        end else begin
            outputsActive_r <= pinLvl_r[TXA_BIT] && !checkOn_r;
        end
    end

    assign chanI = outWord_r[31:16];
    assign chanQ = outWord_r[15:0];
    assign sampleValid = sampleValid_r;
    assign outputsActive = outputsActive_r;

    // Pointer distance alarms; only the check alarm is valid while checking
    assign ptrDist = wrPtr_r - rdPtr_r;
    always_comb begin
        alarmBits = 4'h0;
        if (!checkOn_r && mode != MODE_BYPASS) begin
            alarmBits[ALARM_COLLIDE_BIT] = (ptrDist == 3'h0);
            alarmBits[ALARM_1AWAY_BIT] = (ptrDist == 3'h0) || (ptrDist == 3'h1) || (ptrDist == 3'h7);
            alarmBits[ALARM_2AWAY_BIT] = alarmBits[ALARM_1AWAY_BIT] || (ptrDist == 3'h2) || (ptrDist == 3'h6);
        end
        alarmBits[CHECK_ALARM_BIT] = chk.checkAlarm;
    end
    assign alarmOutPin = |alarmBits;

    // Pattern checker hookup
    assign chk.checkOn = checkOn_r;
    assign chk.byteStb = dclkEdge;
    assign chk.byteData = linkByte;
    assign chk.align = frameRise;
    assign chk.key = key_r;
    assign chk.resWrite = regWrite && (regAddr == CHECK_RESULT_ADDR);
    assign chk.almClear = regWrite && (regAddr == ALARM_STATUS_ADDR) && !regWData[CHECK_ALARM_BIT];
    assign chk.wData = regWData;

    pattern_checker u_checker (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .chk(chk)
    );

    // Register writes
    assign keyHit = (regAddr >= KEY_BASE_ADDR) && (regAddr <= KEY_LAST_ADDR);
    assign keySel = 3'(regAddr - KEY_BASE_ADDR);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            coreCtrl_r <= CORE_CTRL_RST;
            checkOn_r <= TEST_CTRL_RST;
            syncSel_r <= SYNC_SEL_RST;
            rdOffset_r <= RD_OFFSET_RST;
            key_r <= KEY_RST;
        end else if (regWrite) begin
            if (regAddr == CORE_CTRL_ADDR) begin
                coreCtrl_r <= regWData[2:0];
            end
            if (regAddr == TEST_CTRL_ADDR) begin
                checkOn_r <= regWData[CHECK_ON_BIT];
            end
            if (regAddr == SYNC_SEL_ADDR) begin
                syncSel_r <= regWData[SYNC_SRC_BIT];
            end
            if (regAddr == RD_OFFSET_ADDR) begin
                rdOffset_r <= regWData[2:0];
            end
            if (keyHit) begin
                key_r[keySel] <= regWData;
            end
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRData_r <= 8'h00;
        end else if (regRead) begin
            if (keyHit) begin
                regRData_r <= key_r[keySel];
            end else if (regAddr == CORE_CTRL_ADDR) begin
                regRData_r <= {5'h00, coreCtrl_r};
            end else if (regAddr == TEST_CTRL_ADDR) begin
                regRData_r <= {7'h00, checkOn_r};
            end else if (regAddr == SYNC_SEL_ADDR) begin
                regRData_r <= {7'h00, syncSel_r};
            end else if (regAddr == RD_OFFSET_ADDR) begin
                regRData_r <= {5'h00, rdOffset_r};
            end else if (regAddr == ALARM_STATUS_ADDR) begin
                regRData_r <= {4'h0, alarmBits};
            end else if (regAddr == CHECK_RESULT_ADDR) begin
                regRData_r <= chk.resultBits;
            end else begin
                regRData_r <= 8'h00;
            end
        end else begin
            regRData_r <= 8'h00;
        end
    end
    assign regRData = regRData_r;

    property p_modeDecode;
        @(posedge clk_sys) disable iff (!rst_n)
        (coreCtrl_r == 3'h7) |-> (mode == (syncSel_r ? MODE_SINGLE : MODE_DUAL));
    endproperty
    a_modeDecode: assert property (p_modeDecode) else $error("mode decode wrong");

    property p_bypassOut;
        @(posedge clk_sys) disable iff (!rst_n)
        (readTick && !coreCtrl_r[FIFO_ENA_BIT]) |=> (outWord_r == $past(latest_r)) && sampleValid;
    endproperty
    a_bypassOut: assert property (p_bypassOut) else $error("bypass word not passed");

    property p_bypassPtrHold;
        @(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_BYPASS) ##1 (mode == MODE_BYPASS) |-> $stable(rdPtr_r);
    endproperty
    a_bypassPtrHold: assert property (p_bypassPtrHold) else $error("read pointer moved in bypass");

    property p_wrReset;
        @(posedge clk_sys) disable iff (!rst_n)
        (frameRise && resetAllowed) |=> (wrPtr_r == WR_PTR_RST);
    endproperty
    a_wrReset: assert property (p_wrReset) else $error("write pointer not reset");

    property p_dualRdReset;
        @(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_DUAL && ostrRise) |=> (rdPtr_r == $past(rdOffset_r)) && (divCnt_r == 3'h0);
    endproperty
    a_dualRdReset: assert property (p_dualRdReset) else $error("strobe did not reset read pointer");

    property p_singleRdReset;
        @(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_SINGLE && frameRise) ##1 (!readTick)[*2] |-> wrRstSeen_r;
    endproperty
    a_singleRdReset: assert property (p_singleRdReset) else $error("write reset lost for read side");

    property p_collision;
        @(posedge clk_sys) disable iff (!rst_n)
        (wrPtr_r == rdPtr_r && !checkOn_r && mode != MODE_BYPASS) |-> (alarmBits[2:0] == 3'h7) && alarmOutPin;
    endproperty
    a_collision: assert property (p_collision) else $error("collision alarm missing");

    property p_checkMute;
        @(posedge clk_sys) disable iff (!rst_n)
        checkOn_r ##1 checkOn_r |-> !outputsActive;
    endproperty
    a_checkMute: assert property (p_checkMute) else $error("outputs active in check mode");
endmodule : input_fifo_check
`default_nettype wire

// file: logic/pattern_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pattern_checker
    import fifo_check_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Checker link
    check_if.sink chk
);
    logic [2:0] keyIdx_r;
    logic tracking_r;
    logic [7:0] result_r;
    logic alarm_r;
    logic compareNow;
    logic [7:0] expected;
    logic [7:0] errBits;

    // Compare against the expected key word
    always_comb begin
        compareNow = chk.checkOn && chk.byteStb && (chk.align || tracking_r);
        expected = chk.align ? chk.key[0] : chk.key[keyIdx_r];
        errBits = compareNow ? (chk.byteData ^ expected) : 8'h00;
    end

    // Key position, kept after the first aligning edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tracking_r <= 1'b0;
            keyIdx_r <= 3'h0;
        end else if (!chk.checkOn) begin
            tracking_r <= 1'b0;
            keyIdx_r <= 3'h0;
        end else if (chk.byteStb && chk.align) begin
            tracking_r <= 1'b1;
            keyIdx_r <= 3'h1;
        end else if (chk.byteStb && tracking_r) begin
            keyIdx_r <= keyIdx_r + 3'h1;
        end
    end

    // Sticky result bits; a new error wins over the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_r <= 8'h00;
        end else if (chk.resWrite) begin
            result_r <= (result_r & chk.wData) | errBits;
        end else begin
            result_r <= result_r | errBits;
        end
    end

    // General check alarm
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alarm_r <= 1'b0;
        end else if (chk.almClear) begin
            alarm_r <= |errBits;
        end else begin
            alarm_r <= alarm_r | (|errBits);
        end
    end

    assign chk.resultBits = result_r;
    assign chk.checkAlarm = alarm_r;

    property p_errSets;
        @(posedge clk_sys) disable iff (!rst_n)
        (compareNow && chk.byteData != expected) |=> ((result_r & $past(chk.byteData ^ expected)) != 8'h00);
    endproperty
    a_errSets: assert property (p_errSets) else $error("mismatch did not set result");

    property p_alarmSets;
        @(posedge clk_sys) disable iff (!rst_n)
        (errBits != 8'h00) |=> alarm_r;
    endproperty
    a_alarmSets: assert property (p_alarmSets) else $error("mismatch did not set alarm");

    property p_clearWorks;
        @(posedge clk_sys) disable iff (!rst_n)
        (chk.resWrite && chk.wData == 8'h00 && errBits == 8'h00) |=> (result_r == 8'h00);
    endproperty
    a_clearWorks: assert property (p_clearWorks) else $error("result clear failed");

    property p_keepTracking;
        @(posedge clk_sys) disable iff (!rst_n)
        (tracking_r && chk.checkOn && chk.byteStb && !chk.align) |=> (keyIdx_r == $past(keyIdx_r) + 3'h1);
    endproperty
    a_keepTracking: assert property (p_keepTracking) else $error("key index stalled");
endmodule : pattern_checker
`default_nettype wire

// file: test/input_fifo_sync_and_pattern_check_tb.sv
`timescale 1ns/1ps
`default_nettype none
module input_fifo_sync_and_pattern_check_tb;
    import fifo_check_pkg::*;
    logic clk_sys, rst_n, regWrite, regRead, input_data_clock, frame, convClk, strobe, txAllow;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0] regWData, regRData, dataByte;
    logic [15:0] chanI, chanQ;
    logic sampleValid, outputsActive, alarmOutPin;
    int err_total = 0;
    int n_compared = 0;
    key_set_type k;
    // Rows: register index beside its value after reset
    logic [12:0] rows [8] = '{{CORE_CTRL_ADDR, 8'h07}, {TEST_CTRL_ADDR, 8'h00}, {RD_OFFSET_ADDR, 8'h04},
        {SYNC_SEL_ADDR, 8'h00}, {KEY_BASE_ADDR, 8'h7a}, {KEY_LAST_ADDR, 8'hc6}, {CHECK_RESULT_ADDR, 8'h00},
        {5'h02, 8'h00}};
    input_fifo_check #(.INTERP(2)) i_input_fifo_check (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWData(regWData), .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
        .inputDataClock(input_data_clock), .dataByte(dataByte), .frameMarker(frame), .conversionClock(convClk),
        .outputStrobe(strobe), .transmitAllow(txAllow), .chanI(chanI), .chanQ(chanQ),
        .sampleValid(sampleValid), .outputsActive(outputsActive), .alarmOutPin(alarmOutPin));
    link_source i_link_source (.input_data_clock(input_data_clock), .dataOut(dataByte), .frameOut(frame));
    // System clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Conversion clock, phase unrelated to system clock
    initial begin
        convClk = 1'b0;
        #7;
        forever #80 convClk = ~convClk;
    end
    // Verdict and end of run
    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // Compare seen against expected
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Register write, one strobe cycle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    // Register read, data checked in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        chk("regRData", {8'h00, regRData}, {8'h00, e});
    endtask : rd
    // Bounded wait for a new sample
    task automatic wait_valid;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (sampleValid !== 1'b1 && n < 400);
        if (n >= 400) begin
            err_total++;
            report_and_stop();
        end
    endtask : wait_valid
    // Main sequence
    initial begin
        rst_n = 1'b0;
        regAddr = '0;
        regWData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        strobe = 1'b0;
        txAllow = 1'b1;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        foreach (rows[i]) rd(rows[i][12:8], rows[i][7:0]);
        wr(RD_OFFSET_ADDR, 8'h02);
        rd(RD_OFFSET_ADDR, 8'h02);
        // Bypass, dual and single modes with a constant sample
        for (int m = 0; m < 3; m++) begin
            wr(CORE_CTRL_ADDR, m == 0 ? 8'h06 : 8'h07);
            wr(SYNC_SEL_ADDR, m == 2 ? 8'h01 : 8'h00);
            k = {2{8'h63, 8'h52, 8'h41, 8'(8'h30 + m)}};
            fork
                i_link_source.send_run(k, 6, 8'h00);
                begin
                    repeat (3) @(negedge convClk);
                    strobe <= 1'b1;
                    @(negedge convClk);
                    strobe <= 1'b0;
                end
            join
            repeat (40) @(posedge clk_sys);
            wait_valid();
            chk("chanI", chanI, {8'(8'h30 + m), 8'h41});
            chk("chanQ", chanQ, 16'h5263);
        end
        // Pattern check with one rewritten key word
        wr(SYNC_SEL_ADDR, 8'h00);
        k = KEY_RST;
        k[5] = 8'h3c;
        wr(KEY_BASE_ADDR + 5'h05, 8'h3c);
        wr(TEST_CTRL_ADDR, 8'h01);
        repeat (8) @(posedge clk_sys);
        chk("outputsActive", 16'(outputsActive), 16'h0000);
        i_link_source.send_run(k, 100, 8'h00);
        wr(CHECK_RESULT_ADDR, 8'h00);
        wr(ALARM_STATUS_ADDR, 8'h00);
        rd(CHECK_RESULT_ADDR, 8'h00);
        rd(ALARM_STATUS_ADDR, 8'h00);
        i_link_source.send_run(k, 3, 8'h81);
        repeat (8) @(posedge clk_sys);
        rd(CHECK_RESULT_ADDR, 8'h81);
        rd(ALARM_STATUS_ADDR, 8'h08);
        chk("alarmOutPin", 16'(alarmOutPin), 16'h0001);
        wr(TEST_CTRL_ADDR, 8'h00);
        repeat (8) @(posedge clk_sys);
        chk("outputsActive", 16'(outputsActive), 16'h0001);
        // Reset in mid-run
        @(posedge clk_sys);
        rst_n <= 1'b0;
        #1;
        chk("sampleValid", 16'(sampleValid), 16'h0000);
        chk("chanI", chanI, 16'h0000);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(KEY_BASE_ADDR + 5'h05, KEY_RST[5]);
        rd(RD_OFFSET_ADDR, {5'h00, RD_OFFSET_RST});
        report_and_stop();
    end
endmodule : input_fifo_sync_and_pattern_check_tb
`default_nettype wire

// file: test/link_source.sv
`timescale 1ns/1ps
`default_nettype none
module link_source
    import fifo_check_pkg::*;
(
    // Link pins
    output logic input_data_clock,
    output logic [7:0] dataOut,
    output logic frameOut
);
    // Idle link: clock parked, frame low
    initial begin
        input_data_clock = 1'b0;
        frameOut = 1'b0;
        dataOut = 8'h00;
    end
    // Sends reps key runs; flip corrupts word zero of the last run
    task automatic send_run(input key_set_type key, input int reps, input logic [7:0] flip);
        for (int r = 0; r < reps; r++) begin
            for (int w = 0; w < KEY_WORDS; w++) begin
                dataOut <= key[w] ^ ((r == reps - 1 && w == 0) ? flip : 8'h00);
                if (r == 0 && w == 0) frameOut <= 1'b1;
                #40;
                input_data_clock <= ~input_data_clock;
                #40;
                frameOut <= 1'b0;
            end
        end
        dataOut <= ~dataOut; // Released bus shows no stale value
    endtask : send_run
endmodule : link_source
`default_nettype wire
